// ===== shared/crc_scan_defines.svh
// register offsets, field positions and reset values of the crc scanner
`ifndef CRC_SCAN_DEFINES_SVH
`define CRC_SCAN_DEFINES_SVH
`define OFS_DATA_LO    8'h00
`define OFS_DATA_HI    8'h04
`define OFS_ACC_HI     8'h08
`define OFS_ACC_LO     8'h0C
`define OFS_SHIFT_HI   8'h10
`define OFS_SHIFT_LO   8'h14
`define OFS_XOR_HI     8'h18
`define OFS_XOR_LO     8'h1C
`define OFS_SCAN_CTRL  8'h20
`define OFS_CUR_HI     8'h24
`define OFS_CUR_LO     8'h28
`define OFS_END_HI     8'h2C
`define OFS_END_LO     8'h30
`define OFS_CRC_CFG    8'h34
`define CTL_EN_BIT     7
`define CTL_GO_BIT     6
`define CTL_BUSY_BIT   5
`define CTL_INV_BIT    4
`define CTL_INTERRUPT_MANAGEMENT_BIT   3
`define CTL_MODE_HI    1
`define CTL_MODE_LO    0
`define CFG_DATA_LENGTH_FIELD_HI    7
`define CFG_DATA_LENGTH_FIELD_LO    4
`define CFG_POLYNOMIAL_LENGTH_FIELD_HI    3
`define CFG_POLYNOMIAL_LENGTH_FIELD_LO    0
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define RST_CFG        8'hFF
`define RST_CTRL       5'h00
`define XOR_LO_BIT0    1'b1
`define PROG_WORDS     17'h04000
`endif

// ===== shared/crc_scan_pkg.sv
// types shared by the crc engine and memory scanner
package crc_scan_pkg;
  typedef enum logic [1:0] {
    MODE_CONCURRENT,
    MODE_BURST,
    MODE_PEEK,
    MODE_TRIGGERED
  } access_mode_e;
  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_FETCH
  } scan_state_e;
  typedef struct packed {
    logic         en;
    logic         scan_go_a;
    logic         interrupt_management;
    access_mode_e access_mode_field;
  } scan_ctrl_s;
  typedef struct packed {
    logic [3:0] data_length_field;
    logic [3:0] polynomial_length_field;
  } crc_cfg_s;
endpackage

// ===== rtl/crc_memory_scanner_regs.sv
// crc engine with memory scanner and apb register file
// What this block does
// - writing input data low byte loads the word into the shifter
// - 16-bit accumulator is software writable, reads back, resets to zero
// - shifter view is read-only, resets zero, shows shifter contents
// - tap mask enables terms 15..1; bit 0 always reads one
// - clearing scanner enable resets the scanner fsm and the trigger latch only
// - with go set, each crc ready fetches memory per mode, feeds crc
// - hardware clears go once current address passes end, if idle
// - busy reads one only while a memory fetch is outstanding
// - invalid flag set when current address passes program memory
// - burst mode: interrupt management masks go during interrupts
// - concurrent/triggered suspend on interrupts if set; peek ignores it
// - interrupt masking hides go without clearing the stored bit
// - current address holds next fetch address, increments per fetch
// - end address bounds the scan range
// - address writes while go is set are discarded
// - scanner fields and addresses reset zero; control bit 2 reads zero
// - data and polynomial length fields hold length minus one
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "crc_scan_defines.svh"
`default_nettype none
module crc_memory_scanner_regs #(
  parameter logic [16:0] PROG_WORDS = `PROG_WORDS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic      [15:0] mem_addr,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_valid,
  input  wire logic        irq_active,
  input  wire logic        scan_trigger,
  input  wire logic        peek_slot,
  output logic             cpu_stall
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  crc_scan_pkg::scan_ctrl_s  ctrl_ff;
  crc_scan_pkg::crc_cfg_s    cfg_ff;
  crc_scan_pkg::scan_state_e state_ff;
  logic [15:0] dat_ff;
  logic [15:0] acc_ff;
  logic [15:0] shift_ff;
  logic [4:0]  cnt_ff;
  logic [15:1] xor_ff;
  logic [15:0] cur_ff;
  logic [15:0] end_ff;
  logic        busy_ff;
  logic        inv_ff;
  logic        trig_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        mem_req_ff;
  logic        stall_ff;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] len_mask(input logic [3:0] len);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (i <= int'(len));
    end
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  assign wr_acc   = psel && penable && pready_ff && pwrite;
  assign rd_setup = psel && penable && !pready_ff;
  assign wb       = pwdata[7:0];

  logic go_eff;
  logic suspend;
  logic past_end;
  logic crc_ready;
  logic mode_ok;
  logic start_fetch;
  logic fetch_done;
  assign crc_ready  = cnt_ff == 5'h00;
  assign past_end   = cur_ff > end_ff;
  // interrupts only mask the effective go; peek ignores the option
  assign suspend = ctrl_ff.interrupt_management && irq_active &&
                   ctrl_ff.access_mode_field != crc_scan_pkg::MODE_PEEK;
  assign go_eff  = ctrl_ff.scan_go_a && !suspend;
  always_comb begin
    unique case (ctrl_ff.access_mode_field)
      crc_scan_pkg::MODE_CONCURRENT: mode_ok = 1'b1;
      crc_scan_pkg::MODE_BURST:      mode_ok = 1'b1;
      crc_scan_pkg::MODE_PEEK:       mode_ok = peek_slot;
      crc_scan_pkg::MODE_TRIGGERED:  mode_ok = trig_ff;
    endcase
  end
  assign start_fetch = ctrl_ff.en && go_eff && crc_ready && mode_ok &&
                       !past_end && !inv_ff &&
                       state_ff == crc_scan_pkg::SCAN_IDLE;
  assign fetch_done = state_ff == crc_scan_pkg::SCAN_FETCH && mem_valid;

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      `OFS_DATA_LO:   rd_byte = dat_ff[7:0];
      `OFS_DATA_HI:   rd_byte = dat_ff[15:8];
      `OFS_ACC_HI:    rd_byte = acc_ff[15:8];
      `OFS_ACC_LO:    rd_byte = acc_ff[7:0];
      `OFS_SHIFT_HI:  rd_byte = shift_ff[15:8];
      `OFS_SHIFT_LO:  rd_byte = shift_ff[7:0];
      `OFS_XOR_HI:    rd_byte = xor_ff[15:8];
      `OFS_XOR_LO:    rd_byte = {xor_ff[7:1], `XOR_LO_BIT0};
      `OFS_SCAN_CTRL: rd_byte = {ctrl_ff.en, ctrl_ff.scan_go_a, busy_ff, inv_ff,
                                 ctrl_ff.interrupt_management, 1'b0,
                                 ctrl_ff.access_mode_field};
      `OFS_CUR_HI:    rd_byte = cur_ff[15:8];
      `OFS_CUR_LO:    rd_byte = cur_ff[7:0];
      `OFS_END_HI:    rd_byte = end_ff[15:8];
      `OFS_END_LO:    rd_byte = end_ff[7:0];
      `OFS_CRC_CFG:   rd_byte = cfg_ff;
      default:        mapped  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (clk_en) begin
      pready_ff  <= rd_setup;
      pslverr_ff <= rd_setup && !mapped;
      if (rd_setup) begin
        prdata_ff <= (pwrite || !mapped) ? 32'h00000000 : {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // crc engine
  // ----------------------------------------------------------------
  logic [15:0] pmask;
  logic        fb;
  logic [15:0] acc_step;
  assign pmask    = len_mask(cfg_ff.polynomial_length_field);
  assign fb       = acc_ff[cfg_ff.polynomial_length_field] ^
                    shift_ff[cfg_ff.data_length_field];
  assign acc_step = ({acc_ff[14:0], 1'b0} ^ (fb ? {xor_ff, 1'b1} : 16'h0000))
                    & pmask;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= `RST_CFG;
      xor_ff <= 15'h0000;
      dat_ff <= `RST_WORD;
    end else if (clk_en && wr_acc) begin
      if (hit(paddr, `OFS_CRC_CFG)) begin
        cfg_ff <= wb;
      end
      if (hit(paddr, `OFS_XOR_HI)) begin
        xor_ff[15:8] <= wb;
      end
      if (hit(paddr, `OFS_XOR_LO)) begin
        xor_ff[7:1] <= wb[7:1];
      end
      if (hit(paddr, `OFS_DATA_HI)) begin
        dat_ff[15:8] <= wb;
      end
      if (hit(paddr, `OFS_DATA_LO)) begin
        dat_ff[7:0] <= wb;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= `RST_WORD;
      cnt_ff   <= 5'h00;
    end else if (clk_en) begin
      if (wr_acc && hit(paddr, `OFS_DATA_LO)) begin
        shift_ff <= {dat_ff[15:8], wb};
        cnt_ff   <= 5'({1'b0, cfg_ff.data_length_field} + 5'h01);
      end else if (fetch_done) begin
        shift_ff <= mem_rdata;
        cnt_ff   <= 5'({1'b0, cfg_ff.data_length_field} + 5'h01);
      end else if (!crc_ready) begin
        shift_ff <= {shift_ff[14:0], 1'b0};
        cnt_ff   <= cnt_ff - 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= `RST_WORD;
    end else if (clk_en) begin
      if (wr_acc && hit(paddr, `OFS_ACC_HI)) begin
        acc_ff[15:8] <= wb;
      end else if (wr_acc && hit(paddr, `OFS_ACC_LO)) begin
        acc_ff[7:0] <= wb;
      end else if (!crc_ready) begin
        acc_ff <= acc_step;
      end
    end
  end

  // ----------------------------------------------------------------
  // scanner control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= crc_scan_pkg::scan_ctrl_s'(`RST_CTRL);
    end else if (clk_en) begin
      if (ctrl_ff.scan_go_a && past_end && state_ff == crc_scan_pkg::SCAN_IDLE) begin
        ctrl_ff.scan_go_a <= 1'b0;
      end
      // a software set in the same cycle wins over the hardware clear
      if (wr_acc && hit(paddr, `OFS_SCAN_CTRL)) begin
        ctrl_ff.en                   <= wb[`CTL_EN_BIT];
        ctrl_ff.scan_go_a            <= wb[`CTL_GO_BIT];
        ctrl_ff.interrupt_management <= wb[`CTL_INTERRUPT_MANAGEMENT_BIT];
        ctrl_ff.access_mode_field    <=
          crc_scan_pkg::access_mode_e'(wb[`CTL_MODE_HI:`CTL_MODE_LO]);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_ff <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_ff.en) begin
        trig_ff <= 1'b0;
      end else if (scan_trigger) begin
        trig_ff <= 1'b1; // a new trigger wins over consuming the old one
      end else if (start_fetch) begin
        trig_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= crc_scan_pkg::SCAN_IDLE;
      mem_req_ff <= 1'b0;
      busy_ff    <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_ff.en) begin
        state_ff   <= crc_scan_pkg::SCAN_IDLE;
        mem_req_ff <= 1'b0;
        busy_ff    <= 1'b0;
      end else begin
        unique case (state_ff)
          crc_scan_pkg::SCAN_IDLE: begin
            if (start_fetch) begin
              state_ff   <= crc_scan_pkg::SCAN_FETCH;
              mem_req_ff <= 1'b1;
              busy_ff    <= 1'b1;
            end
          end
          crc_scan_pkg::SCAN_FETCH: begin
            if (mem_valid) begin
              state_ff   <= crc_scan_pkg::SCAN_IDLE;
              mem_req_ff <= 1'b0;
              busy_ff    <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // scan addresses
  // ----------------------------------------------------------------
  logic addr_open;
  assign addr_open = wr_acc && !ctrl_ff.scan_go_a;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= `RST_WORD;
    end else if (clk_en) begin
      if (fetch_done) begin
        cur_ff <= cur_ff + 16'h0001;
      end else if (addr_open && hit(paddr, `OFS_CUR_HI)) begin
        cur_ff[15:8] <= wb;
      end else if (addr_open && hit(paddr, `OFS_CUR_LO)) begin
        cur_ff[7:0] <= wb;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      end_ff <= `RST_WORD;
    end else if (clk_en) begin
      if (addr_open && hit(paddr, `OFS_END_HI)) begin
        end_ff[15:8] <= wb;
      end else if (addr_open && hit(paddr, `OFS_END_LO)) begin
        end_ff[7:0] <= wb;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inv_ff   <= 1'b0;
      stall_ff <= 1'b0;
    end else if (clk_en) begin
      inv_ff   <= {1'b0, cur_ff} >= PROG_WORDS;
      // burst holds the cpu while enabled with go effective and the current address not past end
      stall_ff <= ctrl_ff.en && go_eff && !past_end &&
                  ctrl_ff.access_mode_field == crc_scan_pkg::MODE_BURST;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign mem_req  = mem_req_ff;
  assign mem_addr = cur_ff;
  assign cpu_stall = stall_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_data_load: assert property (clk_en && wr_acc && paddr == `OFS_DATA_LO
    |=> shift_ff[7:0] == $past(pwdata[7:0]))
    else $error("data write did not load shifter");
  a_tap_bit0: assert property (clk_en && rd_setup && !pwrite && paddr == `OFS_XOR_LO
    |=> prdata_ff[0] == 1'b1)
    else $error("tap bit 0 not one");
  a_en_reset_fsm: assert property (clk_en && !ctrl_ff.en
    |=> state_ff == crc_scan_pkg::SCAN_IDLE && !mem_req_ff)
    else $error("fsm not reset by enable clear");
  a_go_hw_clear: assert property (clk_en && ctrl_ff.scan_go_a && past_end &&
    state_ff == crc_scan_pkg::SCAN_IDLE && !(wr_acc && paddr == `OFS_SCAN_CTRL)
    |=> !ctrl_ff.scan_go_a)
    else $error("go not cleared past end");
  a_busy_fetch: assert property (busy_ff == (state_ff == crc_scan_pkg::SCAN_FETCH))
    else $error("busy disagrees with fetch");
  a_end_locked: assert property (clk_en && ctrl_ff.scan_go_a && wr_acc
    |=> $stable(end_ff))
    else $error("end address written while go");
  a_addr_incr: assert property (clk_en && fetch_done && ctrl_ff.en
    |=> cur_ff == $past(cur_ff) + 16'h0001)
    else $error("current address did not step");
  a_irq_suspend: assert property (suspend && state_ff == crc_scan_pkg::SCAN_IDLE
    |=> state_ff == crc_scan_pkg::SCAN_IDLE)
    else $error("fetch started while suspended");
  a_go_kept: assert property (clk_en && suspend && ctrl_ff.scan_go_a && !past_end &&
    !wr_acc |=> ctrl_ff.scan_go_a)
    else $error("interrupt cleared stored go");
  a_wait_shift: assert property (clk_en && fetch_done |=> !crc_ready)
    else $error("fetched word not handed to shifter");

endmodule
`default_nettype wire

// ===== testbench/prog_mem_model.sv
// program memory read-path model that answers scanner fetches
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  lat,
  output logic      [15:0] mem_rdata,
  output logic             mem_valid
);
  logic [1:0] wait_ff;
  // -----------------------------------------------------------------
  // answer path
  // -----------------------------------------------------------------
  // one word per request after lat extra cycles; data bus toggles when idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff   <= 2'h0;
      mem_valid <= 1'b0;
      mem_rdata <= 16'hFFFF;
    end else begin
      mem_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_valid) begin
        if (wait_ff == lat) begin
          mem_valid <= 1'b1;
          mem_rdata <= mem_addr ^ 16'hA5C3;
          wait_ff   <= 2'h0;
        end else begin
          wait_ff <= wait_ff + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the crc engine and memory scanner
`timescale 1ns/1ps
`include "crc_scan_defines.svh"
`default_nettype none
module tb;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        irq_active = 0, scan_trigger = 0, peek_slot = 0, e;
  logic [7:0]  paddr = 8'h00, v;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, mem_req, mem_valid, cpu_stall;
  logic [15:0] mem_addr, mem_rdata, m_acc = 16'h0, m_tap = 16'h0001;
  logic [1:0]  lat = 2'h0, md = 2'h0;
  int          bad_count = 0, check_count = 0, fetches = 0, cyc = 0, dl = 15, pl = 15;
  bit          stall_seen = 0;
  logic [7:0]  zr [9] = '{`OFS_ACC_HI, `OFS_ACC_LO, `OFS_SHIFT_HI, `OFS_SHIFT_LO,
                          `OFS_SCAN_CTRL, `OFS_CUR_HI, `OFS_CUR_LO, `OFS_END_HI, `OFS_END_LO};

  always #12.5 clk = ~clk;

  crc_memory_scanner_regs #(.PROG_WORDS(17'h00020)) DUT (
    .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_valid(mem_valid), .irq_active(irq_active), .scan_trigger(scan_trigger),
    .peek_slot(peek_slot), .cpu_stall(cpu_stall));

  prog_mem_model mem (.clk(clk), .arst_n(arst_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .lat(lat), .mem_rdata(mem_rdata), .mem_valid(mem_valid));

  // -----------------------------------------------------------------
  // reference model and helpers
  // -----------------------------------------------------------------
  function automatic logic [15:0] crc(input logic [15:0] a, d);
    logic fb;
    for (int i = dl; i >= 0; i--) begin
      fb = a[pl] ^ d[i];
      a = a << 1;
      if (fb) a = a ^ m_tap;
    end
    return a;
  endfunction

  task automatic chk(input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // apb master: entered right after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    v = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic w(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, x);
    apb(1'b0, a, 8'h00);
    chk(v, x);
  endtask

  task automatic run_scan(input logic [1:0] m, input logic im, input logic [15:0] lo, hi);
    int n0, n;
    logic msk;
    msk = im && m != 2'b10;
    lat <= 2'($urandom);
    w(`OFS_CUR_HI, lo[15:8]);
    w(`OFS_CUR_LO, lo[7:0]);
    w(`OFS_END_HI, hi[15:8]);
    w(`OFS_END_LO, hi[7:0]);
    n0 = fetches;
    md <= m;
    irq_active <= 1'b1;
    w(`OFS_SCAN_CTRL, {2'b11, 2'b00, im, 1'b0, m});
    w(`OFS_CUR_LO, 8'hEE);
    repeat (30) @(posedge clk);
    chk(fetches != n0, !msk);
    apb(1'b0, `OFS_SCAN_CTRL, 8'h00);
    if (msk) chk(v[6], 1'b1);
    irq_active <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, `OFS_SCAN_CTRL, 8'h00);
      n++;
    end while (v[6] && n < 300);
    chk(fetches - n0, hi - lo + 1);
    chk(v[5:4], {1'b0, hi >= 16'h001F});
    w(`OFS_SCAN_CTRL, 8'h00);
    rc(`OFS_CUR_LO, hi[7:0] + 8'h01);
    rc(`OFS_ACC_LO, m_acc[7:0]);
  endtask

  // -----------------------------------------------------------------
  // monitor, random side inputs and timeout
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (arst_n && mem_valid === 1'b1) begin
      fetches++;
      m_acc = crc(m_acc, mem_rdata);
    end
    if (cpu_stall === 1'b1) begin
      stall_seen = 1;
      chk(md, 2'b01);
    end
    scan_trigger <= ($urandom % 4) == 0;
    peek_slot <= 1'($urandom);
    if (cyc == 20000) begin
      bad_count++;
      wrap_up;
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h27bf));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (zr[i]) rc(zr[i], 8'h00);
    rc(`OFS_XOR_LO, 8'h01);
    apb(1'b0, 8'h3C, 8'h00);
    chk({e, v}, 9'h100);
    w(`OFS_SHIFT_HI, 8'hFF);
    rc(`OFS_SHIFT_HI, 8'h00);
    w(`OFS_SCAN_CTRL, 8'h34);
    rc(`OFS_SCAN_CTRL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      r = $urandom;
      w(`OFS_XOR_HI, r[15:8]);
      w(`OFS_XOR_LO, r[7:0]);
      m_tap = r[15:0] | 16'h0001;
      rc(`OFS_XOR_LO, r[7:0] | 8'h01);
      rc(`OFS_XOR_HI, r[15:8]);
      w(`OFS_CRC_CFG, k ? 8'h7F : 8'hFF);
      dl = k ? 7 : 15;
      r = $urandom;
      w(`OFS_ACC_HI, r[15:8]);
      w(`OFS_ACC_LO, r[7:0]);
      m_acc = r[15:0];
      rc(`OFS_ACC_HI, m_acc[15:8]);
      w(`OFS_DATA_HI, r[31:24]);
      w(`OFS_DATA_LO, r[23:16]);
      m_acc = crc(m_acc, r[31:16]);
      repeat (20) @(posedge clk);
      rc(`OFS_ACC_HI, m_acc[15:8]);
      rc(`OFS_ACC_LO, m_acc[7:0]);
    end
    for (int k = 0; k < 4; k++) run_scan(k[1:0], 1'b1, 16'h0010, 16'h0012);
    chk(stall_seen, 1'b1);
    run_scan(2'b00, 1'b0, 16'h0010, 16'h0012);
    run_scan(2'b01, 1'b0, 16'h0010, 16'h0012);
    run_scan(2'b11, 1'b0, 16'h001E, 16'h001F);
    wrap_up;
  end
endmodule
`default_nettype wire
